/* rtl/tcmdbg_pkg.sv */
// package: coprocessor register decode constants and field layouts for the debug register group
package tcmdbg_pkg;
   // ---------------------------------------------------------------
   // coprocessor register selectors
   // ---------------------------------------------------------------
   localparam logic [2:0] OP1_SYS = 3'h0;
   localparam logic [2:0] OP1_DBG = 3'h3;
   localparam logic [3:0] CRN_PROCID = 4'hd;
   localparam logic [3:0] CRM_PROCID = 4'h1;
   localparam logic [2:0] OP2_PROCID = 3'h1;
   localparam logic [3:0] CRN_TEST = 4'hf;
   localparam logic [3:0] CRM_TEST = 4'h0;
   localparam logic [2:0] OP2_TEST = 3'h0;
   localparam logic [3:0] CRM_DBG_INDEX = 4'h0;
   localparam logic [3:0] CRM_DBG_ITAG = 4'h1;
   localparam logic [3:0] CRM_DBG_DTAG = 4'h2;
   localparam logic [3:0] CRM_DBG_IDATA = 4'h3;
   localparam logic [3:0] CRM_DBG_DDATA = 4'h4;
   // ---------------------------------------------------------------
   // test state register fields
   // ---------------------------------------------------------------
   localparam int TS_DATA_STREAM_DIS_BIT = 12;
   localparam int TS_INSTR_STREAM_DIS_BIT = 11;
   localparam int TS_DATA_FILL_DIS_BIT = 10;
   localparam int TS_INSTR_FILL_DIS_BIT = 9;
   localparam logic [3:0] TS_RESET = 4'h0;
   localparam logic [31:0] PROCID_RESET = 32'h0000_0000;
   // ---------------------------------------------------------------
   // local memory region register fields
   // ---------------------------------------------------------------
   localparam int RGN_BASE_LSB = 12;
   localparam int RGN_SIZE_LSB = 1;
   localparam logic [19:0] RGN_BASE_RESET = 20'h0_0000;
   localparam logic [19:0] ITCM_BASE_FIXED = 20'h0_0000;
   localparam logic [4:0] SZ_128M = 5'h12;
   localparam logic [4:0] SZ_256M = 5'h13;
   localparam logic [4:0] SZ_512M = 5'h14;
   localparam logic [4:0] SZ_1G = 5'h15;
   localparam logic [4:0] SZ_2G = 5'h16;
   localparam logic [4:0] SZ_4G = 5'h17;
   localparam logic [4:0] SZ_4K = 5'h03;
   localparam logic [4:0] SZ_MIN_CODE = 5'h03;
   // debug access targets
   typedef enum logic [2:0] {
      TGT_NONE, TGT_INDEX, TGT_ITAG, TGT_DTAG, TGT_IDATA, TGT_DDATA
   } tcmdbg_tgt_t;
endpackage

/* rtl/tcmdbg_region_match.sv */
// region decoder: turns size code and base into an address hit
module tcmdbg_region_match (
   input wire logic [19:0] base,     // region base, address bits 31:12
   input wire logic [4:0] size_code, // area size encoding
   input wire logic [31:0] addr,     // address under test
   output logic hit                  // address lies in region
);
   logic [5:0] sh;
   logic [31:0] mask;
   // ---------------------------------------------------------------
   // size decode
   // ---------------------------------------------------------------
   // code 3 is 4 KB, each step doubles; 0b10010..0b10111 give 128 MB..4 GB
   always_comb begin
      sh = 6'd0;
      mask = 32'h0000_0000;
      if (size_code >= tcmdbg_pkg::SZ_MIN_CODE && size_code <= tcmdbg_pkg::SZ_4G) begin
         sh = 6'(size_code) + 6'd9;
         mask = (sh >= 6'd32) ? 32'h0000_0000 : (32'hffff_ffff << sh);
      end
      hit = (size_code >= tcmdbg_pkg::SZ_MIN_CODE) && (size_code <= tcmdbg_pkg::SZ_4G)
         && ((addr & mask) == ({base, 12'h000} & mask));
   end
endmodule

/* rtl/tcmdbg_store.sv */
// small storage for debug tag and data words, registered read port
module tcmdbg_store (
   input wire logic mclk,          // core clock
   input wire logic we,            // write strobe
   input wire logic [5:0] addr,    // word address
   input wire logic [31:0] wdata,  // write data
   output logic [31:0] rdata       // registered read data
);
   logic [31:0] mem [0:63];
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // no reset on the array: contents are defined only once written
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

/* rtl/tcmdbg_regs.sv */
// system coprocessor debug register group: trace id, test state, cache debug, local memory steering
//
// Functional notes
// - region size codes 0b10010..0b10111 decode 128 MB through 4 GB.
// - instruction memory base fixed at zero and always reads zero.
// - reset clears both region bases to zero.
// - both area sizes load from the memory size register on the first cycle after reset release.
// - overlapping data accesses are served by instruction memory.
// - overlap in load mode: data reads from data RAM, writes to instruction RAM.
// - 32-bit trace_process_identifier drives trace id pins continuously.
// - process id reached at opcode_1 0, c13, c1, opcode_2 1.
// - test state reached at opcode_1 0, c15, c0, opcode_2 0.
// - test state read returns bits 12..9 in place, all other bits zero.
// - test state write changes only bits 12..9.
// - bits 10 and 9 stop data and instruction line fills on miss.
// - fills suppressed: store hits write through, misses do not allocate.
// - fills suppressed: miss goes to bus as uncacheable access.
// - bits 12 and 11 hold requested word until fill ends.
// - opcode_1 3, c15 debug: c0 index, c1..c4 tags and cache data.
module tcmdbg_regs (
   input wire logic mclk,                  // core clock, 20 MHz
   input wire logic resetn,                // asynchronous reset, active low
   input wire logic cp_wr,                 // coprocessor write transfer strobe
   input wire logic cp_rd,                 // coprocessor read transfer strobe
   input wire logic [2:0] cp_op1,          // opcode_1
   input wire logic [3:0] cp_crn,          // CRn
   input wire logic [3:0] cp_crm,          // CRm
   input wire logic [2:0] cp_op2,          // opcode_2
   input wire logic [31:0] cp_wdata,       // write data from core
   input wire logic [4:0] tcm_size_code,   // size from local memory size register
   input wire logic [19:0] dtcm_base_in,   // data region base from region register write path
   input wire logic dtcm_base_we,          // data region base write strobe
   input wire logic itcm_load_mode,        // instruction RAM in load mode
   input wire logic [31:0] data_addr,      // data access address
   input wire logic data_access,           // data access in this cycle
   input wire logic data_write,            // data access is a write
   input wire logic dcache_miss,           // data cache miss
   input wire logic icache_miss,           // instruction cache miss
   input wire logic dcache_store_hit,      // store hit in data cache
   output logic [31:0] cp_rdata,           // read data to core
   output logic [31:0] trace_procid_out,   // trace process id pins
   output logic [31:0] itcm_region_rd,     // instruction region register read value
   output logic [31:0] dtcm_region_rd,     // data region register read value
   output logic data_to_itcm,              // data access goes to instruction RAM
   output logic data_to_dtcm,              // data access goes to data RAM
   output logic dcache_fill_en,            // data cache may line fill
   output logic icache_fill_en,            // instruction cache may line fill
   output logic dcache_alloc,              // data miss allocates
   output logic store_write_through,       // store hit also updates memory
   output logic biu_uncacheable,           // bus interface issues miss uncacheable
   output logic data_stream_en,            // data streamed during fill
   output logic instr_stream_en            // instruction streamed during fill
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [31:0] procid_ff, nxt_procid;
   logic [3:0] test_ff, nxt_test;
   logic [31:0] dbg_index_ff, nxt_dbg_index;
   logic [19:0] dtcm_base_ff, nxt_dtcm_base;
   logic [4:0] itcm_size_ff, nxt_itcm_size;
   logic [4:0] dtcm_size_ff, nxt_dtcm_size;
   logic size_loaded_ff, nxt_size_loaded;
   logic [31:0] cp_rdata_ff, nxt_cp_rdata;
   logic [31:0] trace_ff;
   logic [31:0] itcm_rd_ff, dtcm_rd_ff;
   logic to_itcm_ff, to_dtcm_ff;
   logic dfill_ff, ifill_ff, dalloc_ff, wt_ff, unc_ff, dstr_ff, istr_ff;
   tcmdbg_pkg::tcmdbg_tgt_t tgt, tgt_q_ff;
   logic sel_procid, sel_test;
   logic itcm_hit, dtcm_hit;
   logic [31:0] mem_rdata;
   logic [5:0] mem_addr;
   logic mem_we;
   logic [3:0] test_rd;
   wire logic [3:0] test_view = test_ff;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // one-hot decode of the coprocessor selectors
   always_comb begin
      sel_procid = (cp_op1 == tcmdbg_pkg::OP1_SYS) && (cp_crn == tcmdbg_pkg::CRN_PROCID)
         && (cp_crm == tcmdbg_pkg::CRM_PROCID) && (cp_op2 == tcmdbg_pkg::OP2_PROCID);
      sel_test = (cp_op1 == tcmdbg_pkg::OP1_SYS) && (cp_crn == tcmdbg_pkg::CRN_TEST)
         && (cp_crm == tcmdbg_pkg::CRM_TEST) && (cp_op2 == tcmdbg_pkg::OP2_TEST);
      tgt = tcmdbg_pkg::TGT_NONE;
      if (cp_op1 == tcmdbg_pkg::OP1_DBG && cp_crn == tcmdbg_pkg::CRN_TEST
         && cp_op2 == 3'h0) begin
         case (cp_crm)
            tcmdbg_pkg::CRM_DBG_INDEX: tgt = tcmdbg_pkg::TGT_INDEX;
            tcmdbg_pkg::CRM_DBG_ITAG: tgt = tcmdbg_pkg::TGT_ITAG;
            tcmdbg_pkg::CRM_DBG_DTAG: tgt = tcmdbg_pkg::TGT_DTAG;
            tcmdbg_pkg::CRM_DBG_IDATA: tgt = tcmdbg_pkg::TGT_IDATA;
            tcmdbg_pkg::CRM_DBG_DDATA: tgt = tcmdbg_pkg::TGT_DDATA;
            default: tgt = tcmdbg_pkg::TGT_NONE;
         endcase
      end
   end

   // debug storage: set in index bits 31:30, word in 3:2; tag and data spaces split
   always_comb begin
      mem_addr = {dbg_index_ff[31:30], 1'b0, dbg_index_ff[4:2]};
      case (tgt)
         tcmdbg_pkg::TGT_ITAG: mem_addr = {2'b00, 2'b00, dbg_index_ff[31:30]};
         tcmdbg_pkg::TGT_DTAG: mem_addr = {2'b00, 2'b01, dbg_index_ff[31:30]};
         tcmdbg_pkg::TGT_IDATA: mem_addr = {1'b1, 1'b0, dbg_index_ff[31:30], dbg_index_ff[3:2]};
         tcmdbg_pkg::TGT_DDATA: mem_addr = {1'b1, 1'b1, dbg_index_ff[31:30], dbg_index_ff[3:2]};
         default: mem_addr = 6'h00;
      endcase
      mem_we = cp_wr && (tgt != tcmdbg_pkg::TGT_NONE) && (tgt != tcmdbg_pkg::TGT_INDEX);
   end

   tcmdbg_store u_store (
      .mclk(mclk),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(cp_wdata),
      .rdata(mem_rdata)
   );

   tcmdbg_region_match u_itcm (
      .base(tcmdbg_pkg::ITCM_BASE_FIXED),
      .size_code(itcm_size_ff),
      .addr(data_addr),
      .hit(itcm_hit)
   );

   tcmdbg_region_match u_dtcm (
      .base(dtcm_base_ff),
      .size_code(dtcm_size_ff),
      .addr(data_addr),
      .hit(dtcm_hit)
   );

   // ---------------------------------------------------------------
   // register next state
   // ---------------------------------------------------------------
   // sizes load from the size register on the first cycle after reset release
   always_comb begin
      nxt_procid = procid_ff;
      nxt_test = test_ff;
      nxt_dbg_index = dbg_index_ff;
      nxt_dtcm_base = dtcm_base_ff;
      nxt_itcm_size = itcm_size_ff;
      nxt_dtcm_size = dtcm_size_ff;
      nxt_size_loaded = 1'b1;
      if (!size_loaded_ff) begin
         nxt_itcm_size = tcm_size_code;
         nxt_dtcm_size = tcm_size_code;
      end
      if (cp_wr && sel_procid) begin
         nxt_procid = cp_wdata;
      end
      if (cp_wr && sel_test) begin
         nxt_test = cp_wdata[12:9];
      end
      if (cp_wr && tgt == tcmdbg_pkg::TGT_INDEX) begin
         nxt_dbg_index = cp_wdata;
      end
      if (dtcm_base_we) begin
         nxt_dtcm_base = dtcm_base_in;
      end
   end

   // read mux; tag and data reads come from registered storage one cycle later
   always_comb begin
      test_rd = test_view;
      nxt_cp_rdata = 32'h0000_0000;
      if (cp_rd && sel_procid) begin
         nxt_cp_rdata = procid_ff;
      end else if (cp_rd && sel_test) begin
         nxt_cp_rdata = {19'h0_0000, test_rd, 9'h000};
      end else if (cp_rd && tgt == tcmdbg_pkg::TGT_INDEX) begin
         nxt_cp_rdata = dbg_index_ff;
      end else if (tgt_q_ff != tcmdbg_pkg::TGT_NONE && tgt_q_ff != tcmdbg_pkg::TGT_INDEX) begin
         nxt_cp_rdata = mem_rdata;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         procid_ff <= tcmdbg_pkg::PROCID_RESET;
         test_ff <= tcmdbg_pkg::TS_RESET;
         dbg_index_ff <= 32'h0000_0000;
         dtcm_base_ff <= tcmdbg_pkg::RGN_BASE_RESET;
         itcm_size_ff <= tcmdbg_pkg::SZ_4K;
         dtcm_size_ff <= tcmdbg_pkg::SZ_4K;
         size_loaded_ff <= 1'b0;
         cp_rdata_ff <= 32'h0000_0000;
         tgt_q_ff <= tcmdbg_pkg::TGT_NONE;
      end else begin
         procid_ff <= nxt_procid;
         test_ff <= nxt_test;
         dbg_index_ff <= nxt_dbg_index;
         dtcm_base_ff <= nxt_dtcm_base;
         itcm_size_ff <= nxt_itcm_size;
         dtcm_size_ff <= nxt_dtcm_size;
         size_loaded_ff <= nxt_size_loaded;
         cp_rdata_ff <= nxt_cp_rdata;
         tgt_q_ff <= cp_rd ? tgt : tcmdbg_pkg::TGT_NONE;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   // steering is registered, so decisions trail the access by one cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trace_ff <= tcmdbg_pkg::PROCID_RESET;
         itcm_rd_ff <= 32'h0000_0000;
         dtcm_rd_ff <= 32'h0000_0000;
         to_itcm_ff <= 1'b0;
         to_dtcm_ff <= 1'b0;
         dfill_ff <= 1'b1;
         ifill_ff <= 1'b1;
         dalloc_ff <= 1'b0;
         wt_ff <= 1'b0;
         unc_ff <= 1'b0;
         dstr_ff <= 1'b1;
         istr_ff <= 1'b1;
      end else begin
         trace_ff <= nxt_procid;
         itcm_rd_ff <= {tcmdbg_pkg::ITCM_BASE_FIXED, 6'h00, nxt_itcm_size, 1'b0};
         dtcm_rd_ff <= {nxt_dtcm_base, 6'h00, nxt_dtcm_size, 1'b0};
         // instruction memory wins on overlap unless load mode reads data RAM
         to_itcm_ff <= data_access && itcm_hit
            && !(dtcm_hit && itcm_load_mode && !data_write);
         to_dtcm_ff <= data_access && dtcm_hit
            && (!itcm_hit || (itcm_load_mode && !data_write));
         dfill_ff <= !nxt_test[1];
         ifill_ff <= !nxt_test[0];
         dalloc_ff <= dcache_miss && !test_ff[1];
         wt_ff <= dcache_store_hit && test_ff[1];
         unc_ff <= (dcache_miss && test_ff[1]) || (icache_miss && test_ff[0]);
         dstr_ff <= !nxt_test[3];
         istr_ff <= !nxt_test[2];
      end
   end

   assign cp_rdata = cp_rdata_ff;
   assign trace_procid_out = trace_ff;
   assign itcm_region_rd = itcm_rd_ff;
   assign dtcm_region_rd = dtcm_rd_ff;
   assign data_to_itcm = to_itcm_ff;
   assign data_to_dtcm = to_dtcm_ff;
   assign dcache_fill_en = dfill_ff;
   assign icache_fill_en = ifill_ff;
   assign dcache_alloc = dalloc_ff;
   assign store_write_through = wt_ff;
   assign biu_uncacheable = unc_ff;
   assign data_stream_en = dstr_ff;
   assign instr_stream_en = istr_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_procid_write;
      cp_wr && sel_procid;
   endsequence

   a_procid_to_pins: assert property (@(posedge mclk) disable iff (!resetn)
      s_procid_write |=> trace_procid_out == $past(cp_wdata))
      else $error("trace id pins did not follow write");

   a_procid_read_back: assert property (@(posedge mclk) disable iff (!resetn)
      cp_rd && sel_procid && !cp_wr |=> cp_rdata == $past(procid_ff))
      else $error("process id read wrong");

   a_test_read_zero: assert property (@(posedge mclk) disable iff (!resetn)
      cp_rd && sel_test |=> cp_rdata[31:13] == 19'h0_0000 && cp_rdata[8:0] == 9'h000)
      else $error("test state read upper or low bits nonzero");

   a_test_write_field: assert property (@(posedge mclk) disable iff (!resetn)
      cp_wr && sel_test |=> test_ff == $past(cp_wdata[12:9]))
      else $error("test state write field wrong");

   a_fill_disable: assert property (@(posedge mclk) disable iff (!resetn)
      1'b1 |=> dcache_fill_en == !test_ff[1] && icache_fill_en == !test_ff[0])
      else $error("fill enable disagrees with test state");

   a_stream_disable: assert property (@(posedge mclk) disable iff (!resetn)
      1'b1 |=> data_stream_en == !test_ff[3] && instr_stream_en == !test_ff[2])
      else $error("stream enable disagrees with test state");

   a_uncached_miss: assert property (@(posedge mclk) disable iff (!resetn)
      dcache_miss && test_ff[1] |=> biu_uncacheable && !dcache_alloc)
      else $error("suppressed miss not uncacheable");

   a_itcm_base_zero: assert property (@(posedge mclk) disable iff (!resetn)
      itcm_region_rd[31:12] == 20'h0_0000)
      else $error("instruction base not zero");

   a_overlap_prio: assert property (@(posedge mclk) disable iff (!resetn)
      data_access && itcm_hit && dtcm_hit && !itcm_load_mode |=> data_to_itcm && !data_to_dtcm)
      else $error("overlap not served by instruction memory");

   a_size_reset_load: assert property (@(posedge mclk) disable iff (!resetn)
      !size_loaded_ff |=> itcm_size_ff == $past(tcm_size_code))
      else $error("size not loaded after reset");
endmodule

/* testbench/tcmdbg_core_model.sv */
// partner model: the core side issuing system coprocessor transfers
module tcmdbg_core_model (
   input wire logic mclk,            // core clock
   input wire logic [31:0] cp_rdata, // read data from the register group
   output logic cp_wr,               // write transfer strobe
   output logic cp_rd,               // read transfer strobe
   output logic [2:0] cp_op1,        // opcode_1
   output logic [3:0] cp_crn,        // CRn
   output logic [3:0] cp_crm,        // CRm
   output logic [2:0] cp_op2,        // opcode_2
   output logic [31:0] cp_wdata      // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // one transfer: driven on the falling edge, taken on the next rising edge
   // ---------------------------------------------------------------
   initial begin
      cp_wr = 1'b0;
      cp_rd = 1'b0;
      cp_op1 = 3'h0;
      cp_crn = 4'h0;
      cp_crm = 4'h0;
      cp_op2 = 3'h0;
      cp_wdata = 32'h0000_0000;
   end
   task xfer(input logic wr, input logic [2:0] o1, input logic [3:0] n, input logic [3:0] m,
             input logic [2:0] o2, input logic [31:0] d, output logic [31:0] rd);
      @(negedge mclk);
      cp_wr = wr;
      cp_rd = !wr;
      cp_op1 = o1;
      cp_crn = n;
      cp_crm = m;
      cp_op2 = o2;
      cp_wdata = d;
      @(posedge mclk);
      @(negedge mclk);
      cp_wr = 1'b0;
      cp_rd = 1'b0;
      // released data lines do not keep the last word, so a stale latch cannot pass
      cp_wdata = ~d;
      rd = cp_rdata;
      // tag and cache data reads come back one cycle later than plain registers
      if (o1 == tcmdbg_pkg::OP1_DBG && m != tcmdbg_pkg::CRM_DBG_INDEX) begin
         @(negedge mclk);
         rd = cp_rdata;
      end
   endtask
endmodule

/* testbench/tcm_trace_test_cache_debug_regs_tb_top.sv */
// testbench: register group driven by the core model and per-cycle access events
module tcm_trace_test_cache_debug_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, cp_wr, cp_rd, itcm_load_mode, data_access, data_write;
   logic dcache_miss, icache_miss, dcache_store_hit, dtcm_base_we;
   logic data_to_itcm, data_to_dtcm, dcache_fill_en, icache_fill_en, dcache_alloc;
   logic store_write_through, biu_uncacheable, data_stream_en, instr_stream_en;
   logic [2:0] cp_op1, cp_op2;
   logic [3:0] cp_crn, cp_crm;
   logic [4:0] tcm_size_code, code;
   logic [19:0] dtcm_base_in;
   logic [31:0] cp_wdata, cp_rdata, trace_procid_out, itcm_region_rd, dtcm_region_rd;
   logic [31:0] data_addr, w, rd, idx, seed;
   logic [32:0] span;
   int err_total = 0;
   int n_compared = 0;
   tcmdbg_core_model core_u (.mclk(mclk), .cp_rdata(cp_rdata), .cp_wr(cp_wr), .cp_rd(cp_rd),
      .cp_op1(cp_op1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata));
   tcmdbg_regs dut_u (.mclk(mclk), .resetn(resetn), .cp_wr(cp_wr), .cp_rd(cp_rd),
      .cp_op1(cp_op1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2),
      .cp_wdata(cp_wdata), .tcm_size_code(tcm_size_code), .dtcm_base_in(dtcm_base_in),
      .dtcm_base_we(dtcm_base_we), .itcm_load_mode(itcm_load_mode), .data_addr(data_addr),
      .data_access(data_access), .data_write(data_write), .dcache_miss(dcache_miss),
      .icache_miss(icache_miss), .dcache_store_hit(dcache_store_hit), .cp_rdata(cp_rdata),
      .trace_procid_out(trace_procid_out), .itcm_region_rd(itcm_region_rd),
      .dtcm_region_rd(dtcm_region_rd), .data_to_itcm(data_to_itcm),
      .data_to_dtcm(data_to_dtcm), .dcache_fill_en(dcache_fill_en),
      .icache_fill_en(icache_fill_en), .dcache_alloc(dcache_alloc),
      .store_write_through(store_write_through), .biu_uncacheable(biu_uncacheable),
      .data_stream_en(data_stream_en), .instr_stream_en(instr_stream_en));
   // ---------------------------------------------------------------
   // clock, comparison and closing
   // ---------------------------------------------------------------
   always #25 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // size code to region bytes: 4K code 3 means 2^12
   function automatic logic [32:0] region_bytes(input logic [4:0] c);
      // six-bit shift amount: code 0b10111 plus 9 is 32 and must not wrap to zero
      return 33'h0_0000_0001 << (6'(c) + 6'd9);
   endfunction
   // ---------------------------------------------------------------
   // stimulus helpers: reset with a size, one event cycle
   // ---------------------------------------------------------------
   task automatic rst(input logic [4:0] c);
      @(negedge mclk);
      resetn = 1'b0;
      tcm_size_code = c;
      repeat (6) @(negedge mclk);
      resetn = 1'b1;
      // sizes load and show in the region reads on the same first edge
      repeat (2) @(negedge mclk);
   endtask
   task automatic pulse(input logic acc, input logic wr, input logic [31:0] a,
                        input logic dm, input logic im, input logic sh);
      @(negedge mclk);
      data_access = acc;
      data_write = wr;
      data_addr = a;
      dcache_miss = dm;
      icache_miss = im;
      dcache_store_hit = sh;
      @(negedge mclk);
      {data_access, data_write, dcache_miss, icache_miss, dcache_store_hit} = 5'h00;
      data_addr = ~a;
   endtask
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      {mclk, resetn, itcm_load_mode, dtcm_base_we} = 4'h0;
      {data_access, data_write, dcache_miss, icache_miss, dcache_store_hit} = 5'h00;
      tcm_size_code = tcmdbg_pkg::SZ_4K;
      dtcm_base_in = 20'h0_0000;
      data_addr = 32'h0000_0000;
      seed = $urandom(32'h9831);
      // every upper size code: reset loads it, last word inside hits, first outside misses except for 4 GB, which has no outside
      for (int k = 0; k < 6; k++) begin
         code = tcmdbg_pkg::SZ_128M + 5'(k);
         rst(code);
         chk(itcm_region_rd, {20'h0_0000, 6'h00, code, 1'b0});
         chk(dtcm_region_rd, {20'h0_0000, 6'h00, code, 1'b0});
         chk({dcache_fill_en, icache_fill_en, data_stream_en, instr_stream_en}, 32'h0000_000f);
         span = region_bytes(code);
         pulse(1'b1, 1'b0, span[31:0] - 32'h0000_0004, 1'b0, 1'b0, 1'b0);
         chk({data_to_itcm, data_to_dtcm}, 32'h0000_0002);
         if (!span[32]) begin
            pulse(1'b1, 1'b0, span[31:0], 1'b0, 1'b0, 1'b0);
            chk({data_to_itcm, data_to_dtcm}, 32'h0000_0000);
         end
      end
      $display("test region decode done");
      // overlap in load mode: reads from data RAM, writes to instruction RAM
      itcm_load_mode = 1'b1;
      pulse(1'b1, 1'b0, 32'h0000_0040, 1'b0, 1'b0, 1'b0);
      chk({data_to_itcm, data_to_dtcm}, 32'h0000_0001);
      pulse(1'b1, 1'b1, 32'h0000_0040, 1'b0, 1'b0, 1'b0);
      chk({data_to_itcm, data_to_dtcm}, 32'h0000_0002);
      itcm_load_mode = 1'b0;
      // move the data region clear of the instruction one, base aligned to its size
      rst(tcmdbg_pkg::SZ_128M);
      dtcm_base_in = 20'h1_0000;
      dtcm_base_we = 1'b1;
      @(negedge mclk);
      dtcm_base_we = 1'b0;
      pulse(1'b1, 1'b1, 32'h1000_0004, 1'b0, 1'b0, 1'b0);
      chk({data_to_itcm, data_to_dtcm}, 32'h0000_0001);
      chk(dtcm_region_rd, {20'h1_0000, 6'h00, tcmdbg_pkg::SZ_128M, 1'b0});
      chk(itcm_region_rd[31:12], 32'h0000_0000);
      $display("test overlap steering done");
      // process id: random words reach pins and read back; an unmapped opcode_2 reads zero
      for (int k = 0; k < 4; k++) begin
         w = $urandom();
         core_u.xfer(1'b1, 3'h0, 4'hd, 4'h1, 3'h1, w, rd);
         chk(trace_procid_out, w);
         core_u.xfer(1'b0, 3'h0, 4'hd, 4'h1, 3'h1, 32'h0000_0000, rd);
         chk(rd, w);
      end
      core_u.xfer(1'b0, 3'h0, 4'hd, 4'h1, 3'h2, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      $display("test process id done");
      // test state: all ones corner first, then random words, then clear
      for (int k = 0; k < 8; k++) begin
         w = (k == 0) ? 32'hffff_ffff : ((k == 7) ? 32'h0000_0000 : $urandom());
         core_u.xfer(1'b1, 3'h0, 4'hf, 4'h0, 3'h0, w, rd);
         core_u.xfer(1'b0, 3'h0, 4'hf, 4'h0, 3'h0, 32'h0000_0000, rd);
         chk(rd, {19'h0_0000, w[12:9], 9'h000});
         chk({dcache_fill_en, icache_fill_en, data_stream_en, instr_stream_en},
             {28'h000_0000, ~w[10], ~w[9], ~w[12], ~w[11]});
         pulse(1'b0, 1'b0, 32'h0000_0000, 1'b1, 1'b0, 1'b1);
         chk({dcache_alloc, biu_uncacheable}, {30'h0, ~w[10], w[10]});
         chk(store_write_through, {31'h0, w[10]});
         pulse(1'b0, 1'b0, 32'h0000_0000, 1'b0, 1'b1, 1'b0);
         chk(biu_uncacheable, {31'h0, w[9]});
      end
      $display("test state register done");
      // cache debug: load the index, then write and read each tag and data target
      for (int t = 1; t < 5; t++) begin
         idx = {2'($urandom()), 25'h000_0000, 3'($urandom()), 2'b00};
         core_u.xfer(1'b1, 3'h3, 4'hf, 4'h0, 3'h0, idx, rd);
         core_u.xfer(1'b0, 3'h3, 4'hf, 4'h0, 3'h0, 32'h0000_0000, rd);
         chk(rd, idx);
         w = $urandom();
         core_u.xfer(1'b1, 3'h3, 4'hf, 4'(t), 3'h0, w, rd);
         core_u.xfer(1'b0, 3'h3, 4'hf, 4'(t), 3'h0, 32'h0000_0000, rd);
         chk(rd, w);
      end
      core_u.xfer(1'b0, 3'h3, 4'hf, 4'h5, 3'h0, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      $display("test cache debug done");
      end_of_test();
   end
   // watchdog: the sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      end_of_test();
   end
endmodule
